// file: rtl/fcg_pkg.sv
// Shared constants and types for the fieldbus command gateway.
// Assumes one clock domain; switch levels arrive as asynchronous pins.
package fcg_pkg;

   // Remote register word layout
   localparam int WORD_W     = 16;
   localparam int IDX_W      = 4;
   localparam int NUM_SLOTS  = 4;
   localparam int SLOT_WORDS = 4;

   // Word position inside one slot group of four
   localparam logic [1:0] W_CODE = 2'h0;
   localparam logic [1:0] W_ADDR = 2'h1;
   localparam logic [1:0] W_DLO  = 2'h2;
   localparam logic [1:0] W_DHI  = 2'h3;
   localparam logic [2:0] CNT_LAST  = 3'h3;
   localparam logic [2:0] CNT_FLAG  = 3'h4;

   // Slots 0/1 carry operation data and maintenance, 2/3 carry monitor
   localparam logic [1:0] SLOT_MON_FIRST = 2'h2;
   // Fixed-command transfers reuse the slot 0 and slot 2 word groups
   localparam logic [1:0] FIX_WR_SLOT    = 2'h0;
   localparam logic [1:0] FIX_RD_SLOT    = 2'h2;

   // Maintenance commands share this upper code byte; run only on data 1
   localparam logic [7:0]  MAINT_CLASS = 8'h30;
   localparam logic [31:0] MAINT_GO    = 32'h0000_0001;

   // Switch decoding
   localparam logic [3:0] BAUD_SEL_10M  = 4'h4;
   localparam logic [3:0] BAUD_SEL_MAX  = BAUD_SEL_10M;
   localparam logic [3:0] DIGIT_MAX     = 4'h9;
   localparam logic [6:0] STATION_TENS  = 7'h0a;
   localparam logic [3:0] OP_MODE_NORMAL = 4'h0;

   // Kind of transfer offered to the serial side
   typedef enum logic [1:0]
   {
      KIND_DATA    = 2'h0,
      KIND_MAINT   = 2'h1,
      KIND_MONITOR = 2'h2,
      KIND_READ    = 2'h3
   } fcg_kind_e;

   // Transfer sequencer states
   typedef enum logic [5:0]
   {
      ST_IDLE  = 6'h01,
      ST_FETCH = 6'h02,
      ST_CHECK = 6'h04,
      ST_ISSUE = 6'h08,
      ST_WAIT  = 6'h10,
      ST_STORE = 6'h20
   } fcg_state_e;

   // First word index of a slot group
   function automatic logic [IDX_W-1:0] slot_base(input logic [1:0] slot);
      slot_base = {slot, 2'h0};
   endfunction

endpackage

// file: rtl/fcg_word_mem.sv
// Small word memory with one write port and one registered read port.
// Assumes both ports run on mclk; read data appear one edge after raddr.
`timescale 1ns/100ps
module fcg_word_mem #(
   parameter int DW = 16,
   parameter int AW = 4
)(
   input  wire logic          mclk,
   input  wire logic          arst_n,
   input  wire logic          we,
   input  wire logic [AW-1:0] waddr,
   input  wire logic [DW-1:0] wdata,
   input  wire logic [AW-1:0] raddr,
   output logic      [DW-1:0] rdata
);
   typedef struct packed
   {
      logic [(1<<AW)-1:0][DW-1:0] mem;
      logic [DW-1:0]              rdata;
   } fcg_mem_s;

   fcg_mem_s r;
   fcg_mem_s next_r;

   // Read first: a same-address collision returns the old word
   always_comb
   begin
      next_r = r;
      next_r.rdata = r.mem[raddr];
      if (we)
      begin
         next_r.mem[waddr] = wdata;
      end
   end

   // Cleared at reset so the master never reads stale words
   always_ff @(posedge mclk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         r <= '0;
      end
      else
      begin
         r <= next_r;
      end
   end

   assign rdata = r.rdata;
endmodule // fcg_word_mem

// file: rtl/fcg_gateway.sv
// Fieldbus command gateway: remote words and request bits from the
// master station become transfers toward motor drivers on the serial side.
// Assumes master words, request bits and driver handshake are on mclk;
// the rotary and DIP switches are asynchronous pins.
// Behaviour
// - Selection mode: slot words give code, address, data; request bit starts it
// - Fixation mode uses fixed code and address; master sends only data
// - Fixation mode: write request bit starts a data write to the driver
// - Fixation mode: read request bit starts a data read, never a monitor
// - Slot 0 uses write words 0-3/read 0-3, slot 1 words 4-7
// - Slot 2 uses write/read words 8-B, slot 3 words C-F, monitor
// - Axis-count switch sets how many drivers are reachable
// - Baud-select switch picks bit rate; 4 is 10 Mbps, factory 0
// - Station number is tens digit times ten plus units digit
// - Normal operation only with all four mode switches off
// - On success set completion bit; echo code, address, data (driver data for reads, monitors)
// - Maintenance commands execute only when the data field equals 1
`timescale 1ns/100ps
module fcg_gateway
   import fcg_pkg::*;
#(
   parameter logic [15:0] FIX_WR_CODE = 16'h0000,
   parameter logic [15:0] FIX_RD_CODE = 16'h0000,
   parameter logic [15:0] FIX_ADDR    = 16'h0000
)(
   input  wire logic                     mclk,
   input  wire logic                     arst_n,
   input  wire logic                     cmd_fixation_mode,
   input  wire logic [fcg_pkg::NUM_SLOTS-1:0] data_req,
   input  wire logic                     wr_req,
   input  wire logic                     rd_req,
   input  wire logic                     rww_we,
   input  wire logic [fcg_pkg::IDX_W-1:0]  rww_waddr,
   input  wire logic [fcg_pkg::WORD_W-1:0] rww_wdata,
   input  wire logic [fcg_pkg::IDX_W-1:0]  rwr_raddr,
   output logic      [fcg_pkg::WORD_W-1:0] rwr_rdata,
   output logic      [fcg_pkg::NUM_SLOTS-1:0] data_end,
   output logic                          wr_end,
   output logic                          rd_end,
   output logic      [fcg_pkg::NUM_SLOTS-1:0] slot_error,
   output logic                          drv_req_valid,
   input  wire logic                     drv_req_ready,
   output fcg_pkg::fcg_kind_e            drv_req_kind,
   output logic      [15:0]              drv_req_code,
   output logic      [15:0]              drv_req_addr,
   output logic      [31:0]              drv_req_data,
   input  wire logic                     drv_rsp_valid,
   input  wire logic                     drv_rsp_ok,
   input  wire logic [31:0]              drv_rsp_data,
   input  wire logic [3:0]               axis_count_switch,
   input  wire logic [3:0]               baud_select_switch,
   input  wire logic [3:0]               station_units_switch,
   input  wire logic [3:0]               station_tens_switch,
   input  wire logic [3:0]               op_mode_switch,
   output logic      [3:0]               driver_count,
   output logic      [2:0]               rate_sel,
   output logic                          rate_valid,
   output logic      [6:0]               station_num,
   output logic                          station_valid,
   output logic                          normal_mode
);
   import fcg_pkg::*;

   localparam int SW_W = 20;

   typedef struct packed
   {
      logic [SW_W-1:0]      sw_meta;
      logic [SW_W-1:0]      sw_sync;
      fcg_state_e           state;
      logic [1:0]           slot;
      logic                 fixed_op;
      logic                 fixed_wr;
      logic [2:0]           cnt;
      logic [15:0]          code;
      logic [15:0]          addr;
      logic [15:0]          dlo;
      logic [15:0]          dhi;
      logic [NUM_SLOTS-1:0] data_end;
      logic [NUM_SLOTS-1:0] slot_error;
      logic                 wr_end;
      logic                 rd_end;
      logic [IDX_W-1:0]     rww_idx;
      logic                 rwr_we;
      logic [IDX_W-1:0]     rwr_idx;
      logic [WORD_W-1:0]    rwr_data;
      logic                 drv_valid;
      fcg_kind_e            drv_kind;
      logic [3:0]           driver_count;
      logic [2:0]           rate_sel;
      logic                 rate_valid;
      logic [6:0]           station_num;
      logic                 station_valid;
      logic                 normal_mode;
   } fcg_regs_s;

   fcg_regs_s           r;
   fcg_regs_s           next_r;
   logic [WORD_W-1:0]   rww_rdata;

   // Pick one word of the result group
   function automatic logic [WORD_W-1:0] word_of(input fcg_regs_s s,
                                                  input logic [1:0] idx);
      unique case (idx)
         W_CODE:  word_of = s.code;
         W_ADDR:  word_of = s.addr;
         W_DLO:   word_of = s.dlo;
         default: word_of = s.dhi;
      endcase
   endfunction

   // Kind of transfer from the slot group and the command code
   function automatic fcg_kind_e kind_of(input logic [1:0] slot,
                                         input logic fixed_op,
                                         input logic fixed_wr,
                                         input logic [15:0] code);
      if (fixed_op)
         kind_of = fixed_wr ? KIND_DATA : KIND_READ;
      else if (slot >= SLOT_MON_FIRST)
         kind_of = KIND_MONITOR;
      else if (code[15:8] == MAINT_CLASS)
         kind_of = KIND_MAINT;
      else
         kind_of = KIND_DATA;
   endfunction

   // Master-written words; the sequencer reads them one per cycle
   fcg_word_mem #(
      .DW (WORD_W),
      .AW (IDX_W)
   ) u_rww_mem (
      .mclk   (mclk),
      .arst_n (arst_n),
      .we     (rww_we),
      .waddr  (rww_waddr),
      .wdata  (rww_wdata),
      .raddr  (next_r.rww_idx),
      .rdata  (rww_rdata)
   );

   // Result words returned to the master
   fcg_word_mem #(
      .DW (WORD_W),
      .AW (IDX_W)
   ) u_rwr_mem (
      .mclk   (mclk),
      .arst_n (arst_n),
      .we     (r.rwr_we),
      .waddr  (r.rwr_idx),
      .wdata  (r.rwr_data),
      .raddr  (rwr_raddr),
      .rdata  (rwr_rdata)
   );

   // Next-state logic for switches, request bits and the sequencer
   always_comb
   begin
      next_r = r;
      // Two-stage synchroniser; only sw_sync is decoded
      next_r.sw_meta = {axis_count_switch, baud_select_switch,
                        station_units_switch, station_tens_switch, op_mode_switch};
      next_r.sw_sync = r.sw_meta;

      // Switch decode, registered so outputs stay glitch free
      next_r.driver_count  = r.sw_sync[19:16];
      next_r.rate_valid    = r.sw_sync[15:12] <= BAUD_SEL_MAX;
      next_r.rate_sel      = r.sw_sync[14:12];
      next_r.station_num   = 7'(r.sw_sync[7:4]) * STATION_TENS
                             + 7'(r.sw_sync[11:8]);
      next_r.station_valid = (r.sw_sync[11:8] <= DIGIT_MAX)
                             && (r.sw_sync[7:4] <= DIGIT_MAX)
                             && (r.station_num != 7'h00);
      next_r.normal_mode   = r.sw_sync[3:0] == OP_MODE_NORMAL;

      next_r.rwr_we = 1'b0;

      // Completion drops once the master withdraws its request; slot errors drop whenever data_req of that slot is low
      for (int i = 0; i < NUM_SLOTS; i++)
      begin
         if (!data_req[i])
         begin
            next_r.data_end[i]   = 1'b0;
            next_r.slot_error[i] = 1'b0;
         end
      end
      if (!wr_req)
      begin
         next_r.wr_end = 1'b0;
      end
      if (!rd_req)
      begin
         next_r.rd_end = 1'b0;
      end

      unique case (r.state)
         ST_IDLE:
         begin
            // New transfers only start in normal operation
            if (r.normal_mode && cmd_fixation_mode)
            begin
               if (wr_req && !r.wr_end && !r.slot_error[FIX_WR_SLOT])
               begin
                  next_r.slot     = FIX_WR_SLOT;
                  next_r.fixed_op = 1'b1;
                  next_r.fixed_wr = 1'b1;
                  next_r.state    = ST_FETCH;
               end
               else if (rd_req && !r.rd_end && !r.slot_error[FIX_RD_SLOT])
               begin
                  next_r.slot     = FIX_RD_SLOT;
                  next_r.fixed_op = 1'b1;
                  next_r.fixed_wr = 1'b0;
                  next_r.state    = ST_FETCH;
               end
            end
            else if (r.normal_mode)
            begin
               // Lowest pending slot wins; the loop runs downward
               for (int i = NUM_SLOTS - 1; i >= 0; i--)
               begin
                  if (data_req[i] && !r.data_end[i] && !r.slot_error[i])
                  begin
                     next_r.slot     = 2'(i);
                     next_r.fixed_op = 1'b0;
                     next_r.fixed_wr = 1'b0;
                     next_r.state    = ST_FETCH;
                  end
               end
            end
            next_r.cnt     = 3'h0;
            next_r.rww_idx = slot_base(next_r.slot);
         end

         ST_FETCH:
         begin
            // One word per cycle from the slot group
            unique case (r.cnt[1:0])
               W_CODE:  next_r.code = r.fixed_op ? (r.fixed_wr ? FIX_WR_CODE
                                                   : FIX_RD_CODE) : rww_rdata;
               W_ADDR:  next_r.addr = r.fixed_op ? FIX_ADDR : rww_rdata;
               W_DLO:   next_r.dlo  = rww_rdata;
               default: next_r.dhi  = rww_rdata;
            endcase
            next_r.cnt     = r.cnt + 3'h1;
            next_r.rww_idx = slot_base(r.slot) + IDX_W'(next_r.cnt[1:0]);
            if (r.cnt == CNT_LAST)
            begin
               next_r.state = ST_CHECK;
            end
         end

         ST_CHECK:
         begin
            next_r.drv_kind = kind_of(r.slot, r.fixed_op, r.fixed_wr, r.code);
            // Unreachable driver, or a maintenance command not armed with 1
            if ((r.addr >= 16'(r.driver_count))
                || ((next_r.drv_kind == KIND_MAINT)
                    && ({r.dhi, r.dlo} != MAINT_GO)))
            begin
               next_r.slot_error[r.slot] = 1'b1;
               next_r.state              = ST_IDLE;
            end
            else
            begin
               next_r.drv_valid = 1'b1;
               next_r.state     = ST_ISSUE;
            end
         end

         ST_ISSUE:
         begin
            if (drv_req_ready)
            begin
               next_r.drv_valid = 1'b0;
               next_r.state     = ST_WAIT;
            end
         end

         ST_WAIT:
         begin
            if (drv_rsp_valid && drv_rsp_ok)
            begin
               // Reads and monitors return driver data; writes echo theirs
               if ((r.drv_kind == KIND_MONITOR) || (r.drv_kind == KIND_READ))
               begin
                  {next_r.dhi, next_r.dlo} = drv_rsp_data;
               end
               next_r.cnt   = 3'h0;
               next_r.state = ST_STORE;
            end
            else if (drv_rsp_valid)
            begin
               next_r.slot_error[r.slot] = 1'b1;
               next_r.state              = ST_IDLE;
            end
         end

         ST_STORE:
         begin
            if (r.cnt == CNT_FLAG)
            begin
               // Last word lands this edge, so the flag never leads the data
               if (r.fixed_op && r.fixed_wr)
                  next_r.wr_end = 1'b1;
               else if (r.fixed_op)
                  next_r.rd_end = 1'b1;
               else
                  next_r.data_end[r.slot] = 1'b1;
               next_r.state = ST_IDLE;
            end
            else
            begin
               next_r.rwr_we   = 1'b1;
               next_r.rwr_idx  = slot_base(r.slot) + IDX_W'(r.cnt[1:0]);
               next_r.rwr_data = word_of(r, r.cnt[1:0]);
               next_r.cnt      = r.cnt + 3'h1;
            end
         end

         default:
         begin
            next_r.state     = ST_IDLE;
            next_r.drv_valid = 1'b0;
         end
      endcase
   end

   // Single state register; enum reset code set explicitly
   always_ff @(posedge mclk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         r       <= '0;
         r.state <= ST_IDLE;
      end
      else
      begin
         r <= next_r;
      end
   end

   // Outputs straight from the state register
   assign data_end      = r.data_end;
   assign wr_end        = r.wr_end;
   assign rd_end        = r.rd_end;
   assign slot_error    = r.slot_error;
   assign drv_req_valid = r.drv_valid;
   assign drv_req_kind  = r.drv_kind;
   assign drv_req_code  = r.code;
   assign drv_req_addr  = r.addr;
   assign drv_req_data  = {r.dhi, r.dlo};
   assign driver_count  = r.driver_count;
   assign rate_sel      = r.rate_sel;
   assign rate_valid    = r.rate_valid;
   assign station_num   = r.station_num;
   assign station_valid = r.station_valid;
   assign normal_mode   = r.normal_mode;
endmodule // fcg_gateway

// file: bench/fcg_gateway_chk.sv
// Port checker for the command gateway.
// Assumes it is bound onto fcg_gateway and sees its ports only.
`timescale 1ns/100ps
module fcg_gateway_chk
   import fcg_pkg::*;
(
   input wire logic      mclk,
   input wire logic      arst_n,
   input wire logic [3:0] data_req,
   input wire logic [3:0] data_end,
   input wire logic [3:0] slot_error,
   input wire logic      drv_req_valid,
   input wire logic      drv_req_ready,
   input wire fcg_kind_e drv_req_kind,
   input wire logic [15:0] drv_req_code,
   input wire logic [15:0] drv_req_addr,
   input wire logic [31:0] drv_req_data,
   input wire logic [3:0] driver_count,
   input wire logic [3:0] baud_select_switch,
   input wire logic [3:0] station_units_switch,
   input wire logic [3:0] station_tens_switch,
   input wire logic [3:0] op_mode_switch,
   input wire logic [2:0] rate_sel,
   input wire logic      rate_valid,
   input wire logic [6:0] station_num,
   input wire logic      station_valid,
   input wire logic      normal_mode
);
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!arst_n);

   // Switch held long enough to pass sync and decode
   // One extra cycle covers the edge at which reset lets go
   sequence s_baud_ten;
      (baud_select_switch == BAUD_SEL_10M) [*5];
   endsequence
   sequence s_station_one;
      (station_units_switch == 4'h1 && station_tens_switch == 4'h0) [*6];
   endsequence
   sequence s_mode_off;
      (op_mode_switch == OP_MODE_NORMAL) [*5];
   endsequence

   // Per-slot completion handshake
   for (genvar i = 0; i < 4; i++)
   begin : g_slot
      end_cause_a: assert property ($rose(data_end[i]) |-> $past(data_req[i]))
         else $error("slot end without request");
      end_clear_a: assert property (data_end[i] && !data_req[i] |-> ##2 !data_end[i])
         else $error("slot end kept after request drop");
      end_excl_a: assert property (!(data_end[i] && slot_error[i]))
         else $error("slot end and error together");
   end

   // Serial-side request must not move while waiting
   hold_req_a: assert property (drv_req_valid && !drv_req_ready |=> drv_req_valid
      && $stable({drv_req_kind, drv_req_code, drv_req_addr, drv_req_data}))
      else $error("driver request changed before accept");
   maint_go_a: assert property (drv_req_valid && drv_req_code[15:8] == MAINT_CLASS
      |-> drv_req_data == MAINT_GO)
      else $error("maintenance issued without go value");
   addr_range_a: assert property (drv_req_valid |-> drv_req_addr < {12'h000, driver_count})
      else $error("driver address beyond axis count");
   baud_dec_a: assert property (s_baud_ten |-> rate_valid && rate_sel == 3'h4)
      else $error("baud switch 4 not decoded");
   station_a: assert property (s_station_one |-> station_valid && station_num == 7'h01)
      else $error("station 1 not decoded");
   normal_mode_a: assert property (s_mode_off |-> normal_mode)
      else $error("normal mode missing with switches off");
endmodule // fcg_gateway_chk

bind fcg_gateway fcg_gateway_chk u_chk (
   .mclk, .arst_n, .data_req, .data_end, .slot_error, .drv_req_valid, .drv_req_ready,
   .drv_req_kind, .drv_req_code, .drv_req_addr, .drv_req_data, .driver_count,
   .baud_select_switch, .station_units_switch, .station_tens_switch, .op_mode_switch,
   .rate_sel, .rate_valid, .station_num, .station_valid, .normal_mode
);

// file: bench/fcg_drv_model.sv
// Behavioural serial-side driver answering gateway transfers.
// Assumes mclk domain; dly sets latency, fail makes it answer not-ok.
`timescale 1ns/100ps
module fcg_drv_model (
   input  wire logic        mclk,
   input  wire logic        arst_n,
   input  wire logic        drv_req_valid,
   input  wire logic [3:0]  dly,
   input  wire logic        fail,
   input  wire logic [31:0] mon_value,
   output logic             drv_req_ready,
   output logic             drv_rsp_valid,
   output logic             drv_rsp_ok,
   output logic [31:0]      drv_rsp_data
);
   logic       busy;
   logic [3:0] cnt;

   // Accept after dly, answer dly later; idle lines toggle so stale data never matches
   always_ff @(posedge mclk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         {drv_req_ready, drv_rsp_valid, drv_rsp_ok, busy} <= '0;
         drv_rsp_data <= '0;
         cnt          <= '0;
      end
      else
      begin
         drv_req_ready <= 1'b0;
         drv_rsp_valid <= 1'b0;
         drv_rsp_ok    <= ~drv_rsp_ok;
         drv_rsp_data  <= ~drv_rsp_data;
         cnt           <= cnt + 4'h1;
         if (!busy && !(drv_req_valid && !drv_req_ready))
            cnt <= '0;
         else if (!busy && cnt >= dly)
         begin
            drv_req_ready <= 1'b1;
            busy          <= 1'b1;
            cnt           <= '0;
         end
         else if (busy && cnt >= dly)
         begin
            drv_rsp_valid <= 1'b1;
            drv_rsp_ok    <= !fail;
            drv_rsp_data  <= mon_value;
            busy          <= 1'b0;
         end
      end
   end
endmodule // fcg_drv_model

// file: bench/tb.sv
// Self-checking bench for the command gateway and a driver model.
// Assumes package, gateway, checker and model are compiled first.
`timescale 1ns/100ps
module tb;
   import fcg_pkg::*;
   localparam logic [15:0] WR_CODE = 16'h0a11;
   localparam logic [15:0] RD_CODE = 16'h0b22;
   localparam logic [15:0] FADDR   = 16'h0001;
   logic mclk = 1'b0;
   logic arst_n, cmd_fixation_mode, wr_req, rd_req, rww_we, wr_end, rd_end, fail;
   logic drv_req_valid, drv_req_ready, drv_rsp_valid, drv_rsp_ok;
   logic rate_valid, station_valid, normal_mode;
   logic [3:0] data_req, data_end, slot_error, rww_waddr, rwr_raddr, driver_count, dly;
   logic [3:0] axis_count_switch, baud_select_switch, op_mode_switch;
   logic [3:0] station_units_switch, station_tens_switch;
   logic [15:0] rww_wdata, rwr_rdata, drv_req_code, drv_req_addr;
   logic [31:0] drv_req_data, drv_rsp_data, mon_value;
   logic [2:0] rate_sel;
   logic [6:0] station_num;
   fcg_kind_e drv_req_kind;
   int err_count, total_checks;

   always #50 mclk = ~mclk;

   fcg_gateway #(.FIX_WR_CODE(WR_CODE), .FIX_RD_CODE(RD_CODE), .FIX_ADDR(FADDR)) u_dut (
      .mclk, .arst_n, .cmd_fixation_mode, .data_req, .wr_req, .rd_req, .rww_we, .rww_waddr,
      .rww_wdata, .rwr_raddr, .rwr_rdata, .data_end, .wr_end, .rd_end, .slot_error,
      .drv_req_valid, .drv_req_ready, .drv_req_kind, .drv_req_code, .drv_req_addr,
      .drv_req_data, .drv_rsp_valid, .drv_rsp_ok, .drv_rsp_data, .axis_count_switch,
      .baud_select_switch, .station_units_switch, .station_tens_switch, .op_mode_switch,
      .driver_count, .rate_sel, .rate_valid, .station_num, .station_valid, .normal_mode);
   fcg_drv_model u_drv (.mclk, .arst_n, .drv_req_valid, .dly, .fail, .mon_value,
      .drv_req_ready, .drv_rsp_valid, .drv_rsp_ok, .drv_rsp_data);

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp)
      begin
         err_count++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // Four back-to-back word writes into one slot group
   task automatic wr4(input logic [3:0] b, input logic [15:0] c, a, input logic [31:0] d);
      logic [15:0] w [4];
      w = '{c, a, d[15:0], d[31:16]};
      for (int k = 0; k < 4; k++)
      begin
         @(posedge mclk);
         rww_we    <= 1'b1;
         rww_waddr <= b + 4'(k);
         rww_wdata <= w[k];
      end
      @(posedge mclk);
      rww_we <= 1'b0;
   endtask

   // Result read is registered: sample one edge after the index
   task automatic chk4(input logic [3:0] b, input logic [15:0] c, a, input logic [31:0] d);
      logic [15:0] w [4];
      w = '{c, a, d[15:0], d[31:16]};
      for (int k = 0; k < 4; k++)
      begin
         @(posedge mclk);
         rwr_raddr <= b + 4'(k);
         @(posedge mclk);
         @(negedge mclk);
         chk(rwr_rdata, w[k]);
      end
   endtask

   // Bounded wait; 4 and 5 mean the fixation write and read
   task automatic await(input int s);
      for (int k = 0; k < 300; k++)
      begin
         @(negedge mclk);
         if (s < 4 && (data_end[s] || slot_error[s])) break;
         if (s == 4 && (wr_end || slot_error[0])) break;
         if (s == 5 && (rd_end || slot_error[2])) break;
      end
   endtask

   task automatic drop_wait;
      repeat (3) @(posedge mclk);
      @(negedge mclk);
      chk({data_end, slot_error, wr_end, rd_end}, 32'h0);
   endtask

   task automatic run(input int s, input logic [15:0] c, a, input logic [31:0] d,
                      input logic ok, input logic [31:0] e);
      wr4(4'(s * 4), c, a, d);
      @(posedge mclk);
      data_req[s] <= 1'b1;
      await(s);
      chk({data_end[s], slot_error[s]}, {ok, !ok});
      chk(drv_req_kind, (s >= 2) ? KIND_MONITOR
          : (c[15:8] == MAINT_CLASS) ? KIND_MAINT : KIND_DATA);
      if (ok) chk4(4'(s * 4), c, a, e);
      @(posedge mclk);
      data_req[s] <= 1'b0;
      drop_wait();
   endtask

   task automatic fixrun(input logic wr, input logic [3:0] b, input logic [15:0] c,
                         input logic [31:0] d, input logic [31:0] e);
      @(posedge mclk);
      cmd_fixation_mode <= 1'b1;
      wr4(b, 16'h0000, 16'h0000, d);
      @(posedge mclk);
      wr_req <= wr;
      rd_req <= !wr;
      await(wr ? 4 : 5);
      chk({wr_end, rd_end}, {wr, !wr});
      chk(drv_req_kind, wr ? KIND_DATA : KIND_READ);
      chk4(b, c, FADDR, e);
      @(posedge mclk);
      wr_req <= 1'b0;
      rd_req <= 1'b0;
      cmd_fixation_mode <= 1'b0;
      drop_wait();
   endtask

   task automatic t_switches;
      chk(driver_count, 4'h2);
      chk({station_valid, station_num}, 8'h81);
      chk(normal_mode, 1'b1);
      for (int v = 7; v >= 0; v--)
      begin
         @(posedge mclk);
         baud_select_switch <= 4'(v);
         repeat (5) @(posedge mclk);
         @(negedge mclk);
         chk({rate_valid, rate_sel}, {v <= int'(BAUD_SEL_MAX), 3'(v)});
      end
   endtask

   task automatic t_mode;
      @(posedge mclk);
      op_mode_switch <= 4'h1;
      repeat (6) @(posedge mclk);
      data_req[0] <= 1'b1;
      repeat (30) @(posedge mclk);
      @(negedge mclk);
      chk(data_end[0], 1'b0);
      @(posedge mclk);
      op_mode_switch <= 4'h0;
      await(0);
      chk(data_end[0], 1'b1);
      @(posedge mclk);
      data_req[0] <= 1'b0;
      drop_wait();
   endtask

   task automatic print_verdict;
      if (err_count == 0 && total_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   // Run is a few hundred cycles; far beyond that means a hang
   initial
   begin
      repeat (20000) @(posedge mclk);
      err_count++;
      print_verdict();
   end

   initial
   begin
      {arst_n, cmd_fixation_mode, wr_req, rd_req, rww_we, fail} = '0;
      {data_req, rww_waddr, rwr_raddr, rww_wdata, dly, mon_value} = '0;
      {axis_count_switch, baud_select_switch} = {4'h2, 4'h4};
      {station_units_switch, station_tens_switch, op_mode_switch} = {4'h1, 4'h0, 4'h0};
      repeat (5) @(posedge mclk);
      arst_n <= 1'b1;
      repeat (6) @(posedge mclk);
      @(negedge mclk);
      t_switches();
      run(0, 16'h30c5, 16'h0000, 32'h1, 1'b1, 32'h1);
      run(1, 16'h30c5, 16'h0001, 32'h1, 1'b1, 32'h1);
      run(1, 16'h30c5, 16'h0001, 32'h0001_0001, 1'b0, 32'h0);
      @(posedge mclk);
      mon_value <= 32'h1234_abcd;
      run(2, 16'h2066, 16'h0000, 32'h0, 1'b1, 32'h1234_abcd);
      @(posedge mclk);
      dly <= 4'h5;
      run(3, 16'h2066, 16'h0001, 32'h0, 1'b1, 32'h1234_abcd);
      run(0, 16'h0001, 16'h0002, 32'h1388, 1'b0, 32'h0);
      run(0, 16'h0001, 16'h0001, 32'h1388, 1'b1, 32'h1388);
      @(posedge mclk);
      fail <= 1'b1;
      run(1, 16'h0001, 16'h0000, 32'h5, 1'b0, 32'h0);
      @(posedge mclk);
      {fail, dly} <= 5'h00;
      t_mode();
      fixrun(1'b1, 4'h0, WR_CODE, 32'h0001_2345, 32'h0001_2345);
      fixrun(1'b0, 4'h8, RD_CODE, 32'h0, 32'h1234_abcd);
      print_verdict();
   end
endmodule // tb
